/* File: rtl/srcm_pkg.sv */
/*
 Shared constants for the reference-capture monitor: register indices,
 field positions, reset values and widths.
 Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
package srcm_pkg;
    localparam int unsigned ADR_W = 12;
    localparam int unsigned DAT_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [9:0] IDX_SKEW    = 10'h122;
    localparam logic [9:0] IDX_TSDLY   = 10'h123;
    localparam logic [9:0] IDX_SETHOLD = 10'h128;
    localparam logic [9:0] IDX_DIVPH   = 10'h129;
    localparam logic [9:0] IDX_COUNT   = 10'h12a;
    localparam logic [9:0] IDX_SYNC    = 10'h1ff;
    localparam logic [9:0] IDX_APP     = 10'h200;

    // Field positions
    localparam int unsigned SETUP_LSB = 0;
    localparam int unsigned HOLD_LSB  = 4;
    localparam int unsigned POS_LSB   = 0;
    localparam int unsigned NEG_LSB   = 2;
    localparam int unsigned OPM_LSB   = 0;
    localparam int unsigned QIGN_BIT  = 5;

    // Reset values
    localparam logic [7:0] RST_SYNC  = 8'h00;
    localparam logic [7:0] RST_APP   = 8'h00;
    localparam logic [7:0] RST_TSDLY = 8'h00;
    localparam logic [3:0] RST_SKEW  = 4'h0;
    localparam logic [7:0] RST_STAT  = 8'h00;

    // Mode encodings
    localparam logic [1:0] SYNC_NORMAL    = 2'h0;
    localparam logic [1:0] SYNC_TIMESTAMP = 2'h1;
    localparam logic [1:0] OPM_FULL_BW    = 2'h0;
    localparam logic [1:0] OPM_DUAL_DDC   = 2'h1;
    localparam logic [3:0] PHASE_IN_PHASE = 4'h0;

    // Divider period seen by the qualifier, in sample clocks
    localparam int unsigned DIV_LEN = 16;

    typedef enum logic [1:0] {
        TS_IDLE = 2'b01,
        TS_WAIT = 2'b10
    } srcm_ts_state_t;
endpackage

/* File: rtl/srcm_edge_qual.sv */
/*
 Edge qualifier: finds rising reference edges and drops those falling
 inside the negative or positive skew window around a divider boundary.
 Assumes the reference input is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module srcm_edge_qual #(
    parameter int unsigned DIV_LEN = srcm_pkg::DIV_LEN
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       sysref_in,
    input  wire logic [1:0] neg_win,
    input  wire logic [1:0] pos_win,
    output logic            capture_pulse
);
    import srcm_pkg::*;

    localparam int unsigned CW = $clog2(DIV_LEN);

    logic          prev_r;
    logic          prev_nxt;
    logic [CW-1:0] phase_r;
    logic [CW-1:0] phase_nxt;
    logic          cap_r;
    logic          cap_nxt;
    logic [CW-1:0] to_next;
    logic          edge_seen;
    logic          in_pos;
    logic          in_neg;

    always_comb begin
        edge_seen = sysref_in & ~prev_r;
        to_next   = CW'(DIV_LEN) - phase_r;
        // Phase zero is exact capture; windows widen the reject zone
        in_pos    = (phase_r != '0) && (phase_r <= CW'(pos_win));
        in_neg    = (phase_r != '0) && (to_next <= CW'(neg_win));
        prev_nxt  = sysref_in;
        phase_nxt = (phase_r == CW'(DIV_LEN - 1)) ? '0 : phase_r + CW'(1);
        cap_nxt   = edge_seen & ~in_pos & ~in_neg;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_r  <= 1'b0;
            phase_r <= '0;
            cap_r   <= 1'b0;
        end else begin
            prev_r  <= prev_nxt;
            phase_r <= phase_nxt;
            cap_r   <= cap_nxt;
        end
    end

    assign capture_pulse = cap_r;
endmodule

/* File: rtl/srcm_monitor.sv */
/*
 Reference-capture monitor top: Wishbone register file, capture snapshot,
 capture counter, timestamp delay and mode outputs.
 Assumes one 50 MHz clock, synchronous inputs and a classic Wishbone master.
*/
`timescale 1ns/1ps
module srcm_monitor #(
    parameter int unsigned DIV_LEN = srcm_pkg::DIV_LEN
) (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic [srcm_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [srcm_pkg::DAT_W-1:0] wb_dat_i,
    output logic      [srcm_pkg::DAT_W-1:0] wb_dat_o,
    input  wire logic                       wb_we_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic                            wb_ack_o,
    input  wire logic                       sysref_in,
    input  wire logic [3:0]                 setup_margin_in,
    input  wire logic [3:0]                 hold_margin_in,
    input  wire logic [3:0]                 div_phase_in,
    output logic                            capture_out,
    output logic                            timestamp_out,
    output logic [1:0]                      op_mode_out,
    output logic                            q_ignore_out
);
    import srcm_pkg::*;

    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [9:0] idx);
        hit = (adr == {idx, 2'b00});
    endfunction

    // Bus state
    logic             ack_r;
    logic             ack_nxt;
    logic [DAT_W-1:0] rdat_r;
    logic [DAT_W-1:0] rdat_nxt;
    logic             wr_en;
    logic             rd_en;

    // Software registers
    logic [7:0] sync_r;
    logic [7:0] sync_nxt;
    logic [7:0] app_r;
    logic [7:0] app_nxt;
    logic [7:0] tsdly_r;
    logic [7:0] tsdly_nxt;
    logic [3:0] skew_r;
    logic [3:0] skew_nxt;

    // Capture snapshot
    logic [7:0] sethold_r;
    logic [7:0] sethold_nxt;
    logic [3:0] divph_r;
    logic [3:0] divph_nxt;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic       cap_out_r;
    logic       cap_out_nxt;
    logic       cap_ev;

    // Timestamp delay
    srcm_ts_state_t ts_st_r;
    srcm_ts_state_t ts_st_nxt;
    logic [7:0]     ts_cnt_r;
    logic [7:0]     ts_cnt_nxt;
    logic           ts_out_r;
    logic           ts_out_nxt;
    logic           ts_mode;

    srcm_edge_qual #(
        .DIV_LEN (DIV_LEN)
    ) u_qual (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .sysref_in     (sysref_in),
        .neg_win       (skew_r[NEG_LSB +: 2]),
        .pos_win       (skew_r[POS_LSB +: 2]),
        .capture_pulse (cap_ev)
    );

    // Wishbone slave, one wait state, ack drops after one cycle
    always_comb begin
        wr_en    = wb_cyc_i & wb_stb_i & ~ack_r & wb_we_i & wb_sel_i[0];
        rd_en    = wb_cyc_i & wb_stb_i & ~ack_r & ~wb_we_i;
        ack_nxt  = wb_cyc_i & wb_stb_i & ~ack_r;
        rdat_nxt = rdat_r;
        if (rd_en) begin
            rdat_nxt = '0;
            if (hit(wb_adr_i, IDX_SETHOLD)) begin
                rdat_nxt[7:0] = sethold_r;
            end else if (hit(wb_adr_i, IDX_DIVPH)) begin
                rdat_nxt[3:0] = divph_r;
            end else if (hit(wb_adr_i, IDX_COUNT)) begin
                rdat_nxt[7:0] = count_r;
            end else if (hit(wb_adr_i, IDX_SYNC)) begin
                rdat_nxt[7:0] = sync_r;
            end else if (hit(wb_adr_i, IDX_APP)) begin
                rdat_nxt[7:0] = app_r;
            end else if (hit(wb_adr_i, IDX_SKEW)) begin
                rdat_nxt[3:0] = skew_r;
            end else if (hit(wb_adr_i, IDX_TSDLY)) begin
                rdat_nxt[7:0] = tsdly_r;
            end
        end
    end

    // Writable registers, reserved bits kept at zero
    always_comb begin
        sync_nxt  = sync_r;
        app_nxt   = app_r;
        tsdly_nxt = tsdly_r;
        skew_nxt  = skew_r;
        if (wr_en) begin
            if (hit(wb_adr_i, IDX_SYNC)) begin
                sync_nxt = {6'h00, wb_dat_i[1:0]};
            end
            if (hit(wb_adr_i, IDX_APP)) begin
                app_nxt = '0;
                app_nxt[OPM_LSB +: 2] = wb_dat_i[OPM_LSB +: 2];
                app_nxt[QIGN_BIT]     = wb_dat_i[QIGN_BIT];
            end
            if (hit(wb_adr_i, IDX_TSDLY)) begin
                tsdly_nxt = wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, IDX_SKEW)) begin
                skew_nxt = wb_dat_i[3:0];
            end
        end
    end

    // Snapshot of margins, phase and count on one capture
    always_comb begin
        sethold_nxt = sethold_r;
        divph_nxt   = divph_r;
        count_nxt   = count_r;
        cap_out_nxt = cap_ev & ~ts_mode;
        if (cap_ev) begin
            sethold_nxt[HOLD_LSB +: 4]  = hold_margin_in;
            sethold_nxt[SETUP_LSB +: 4] = setup_margin_in;
            divph_nxt = div_phase_in;
            count_nxt = count_r + 8'h01;
        end
    end

    // Timestamp delay, bypassed in normal sync mode
    always_comb begin
        ts_mode    = (sync_r[1:0] == SYNC_TIMESTAMP);
        ts_st_nxt  = ts_st_r;
        ts_cnt_nxt = ts_cnt_r;
        ts_out_nxt = 1'b0;
        case (ts_st_r)
            TS_IDLE: begin
                if (cap_ev && ts_mode) begin
                    if (tsdly_r == 8'h00) begin
                        ts_out_nxt = 1'b1;
                    end else begin
                        ts_cnt_nxt = tsdly_r - 8'h01;
                        ts_st_nxt  = TS_WAIT;
                    end
                end
            end
            TS_WAIT: begin
                if (!ts_mode) begin
                    ts_st_nxt = TS_IDLE;
                end else if (ts_cnt_r == 8'h00) begin
                    ts_out_nxt = 1'b1;
                    ts_st_nxt  = TS_IDLE;
                end else begin
                    ts_cnt_nxt = ts_cnt_r - 8'h01;
                end
            end
            default: begin
                ts_st_nxt = TS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_r     <= 1'b0;
            rdat_r    <= '0;
            sync_r    <= RST_SYNC;
            app_r     <= RST_APP;
            tsdly_r   <= RST_TSDLY;
            skew_r    <= RST_SKEW;
            sethold_r <= RST_STAT;
            divph_r   <= PHASE_IN_PHASE;
            count_r   <= RST_STAT;
            cap_out_r <= 1'b0;
            ts_st_r   <= TS_IDLE;
            ts_cnt_r  <= 8'h00;
            ts_out_r  <= 1'b0;
        end else begin
            ack_r     <= ack_nxt;
            rdat_r    <= rdat_nxt;
            sync_r    <= sync_nxt;
            app_r     <= app_nxt;
            tsdly_r   <= tsdly_nxt;
            skew_r    <= skew_nxt;
            sethold_r <= sethold_nxt;
            divph_r   <= divph_nxt;
            count_r   <= count_nxt;
            cap_out_r <= cap_out_nxt;
            ts_st_r   <= ts_st_nxt;
            ts_cnt_r  <= ts_cnt_nxt;
            ts_out_r  <= ts_out_nxt;
        end
    end

    assign wb_ack_o      = ack_r;
    assign wb_dat_o      = rdat_r;
    assign capture_out   = cap_out_r;
    assign timestamp_out = ts_out_r;
    assign op_mode_out   = app_r[OPM_LSB +: 2];
    assign q_ignore_out  = app_r[QIGN_BIT];
endmodule

/* File: testbench/srcm_chk_monitor.sv */
/*
 Port checker for the capture monitor.
 Assumes a bind onto srcm_monitor.
*/
`timescale 1ns/1ps
module srcm_chk #(
    parameter int unsigned DIV_LEN = 16
) (
    input wire logic                       sys_clk,
    input wire logic                       sys_rst,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_ack_o,
    input wire logic [srcm_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic                       sysref_in,
    input wire logic                       capture_out,
    input wire logic                       timestamp_out,
    input wire logic [1:0]                 op_mode_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");
    rdata_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    capture_edge_a: assert property (capture_out |-> $past(sysref_in, 2) && !$past(sysref_in, 3))
        else $error("capture without rising edge");
    capture_pulse_a: assert property (capture_out |=> !capture_out)
        else $error("capture pulse too long");
    stamp_pulse_a: assert property (timestamp_out |=> !timestamp_out)
        else $error("timestamp pulse too long");
    mode_excl_a: assert property (!(capture_out && timestamp_out))
        else $error("capture and timestamp together");
    op_write_a: assert property ($changed(op_mode_out) |-> wb_ack_o || $past(wb_ack_o))
        else $error("mode changed without write");
endmodule

/* File: testbench/srcm_refgen.sv */
/*
 Reference source model: one-cycle reference per trigger, levels held.
 Assumes triggers at least two cycles apart.
*/
`timescale 1ns/1ps
module srcm_refgen (
    input  wire logic       sys_clk,
    input  wire logic       trig,
    input  wire logic [3:0] setup_v,
    input  wire logic [3:0] hold_v,
    input  wire logic [3:0] phase_v,
    output logic            sysref_in = 1'b0,
    output logic [3:0]      setup_margin_in = 4'h0,
    output logic [3:0]      hold_margin_in = 4'h0,
    output logic [3:0]      div_phase_in = 4'h0
);
    // Levels stay stable until the next trigger
    always @(posedge sys_clk) begin
        sysref_in <= trig;
        if (trig) begin
            setup_margin_in <= setup_v;
            hold_margin_in <= hold_v;
            div_phase_in <= phase_v;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
/*
 Self-checking bench: registers, skew sweeps, counter wrap, timestamp.
 Assumes srcm_pkg, srcm_refgen and srcm_chk.
*/
`timescale 1ns/1ps
module tb_top;
    import srcm_pkg::*;
    localparam int unsigned DIV_LEN = 16;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_ack_o, sysref_in, capture_out, timestamp_out, q_ignore_out, trig = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0]  wb_sel_i = 4'hf, sv = 4'h0, hv = 4'h0, pv = 4'h0, setup_m, hold_m, phase_m;
    logic [1:0]  op_mode_out;
    logic [7:0]  v;
    logic [11:0] ra[8] = '{12'h488, 12'h48c, 12'h4a0, 12'h4a4, 12'h4a8, 12'h7fc, 12'h800, 12'h7f0};
    logic [31:0] exp_q[$];
    int          miscompares = 0, num_checks = 0, cyc_cnt = 0;
    srcm_monitor #(.DIV_LEN(DIV_LEN)) srcm_monitor_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .sysref_in(sysref_in), .setup_margin_in(setup_m), .hold_margin_in(hold_m),
        .div_phase_in(phase_m), .capture_out(capture_out), .timestamp_out(timestamp_out),
        .op_mode_out(op_mode_out), .q_ignore_out(q_ignore_out));
    srcm_refgen srcm_refgen_inst (.sys_clk(sys_clk), .trig(trig), .setup_v(sv), .hold_v(hv),
        .phase_v(pv), .sysref_in(sysref_in), .setup_margin_in(setup_m), .hold_margin_in(hold_m),
        .div_phase_in(phase_m));
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic [11:0] a, input logic we, input logic [31:0] d);
        @(posedge sys_clk);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask
    // Edges 17 cycles apart step the divider phase by one
    task automatic fire(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            {sv, hv, pv} <= 12'($urandom);
            trig <= 1'b1;
            @(posedge sys_clk);
            trig <= 1'b0;
            repeat (15) @(posedge sys_clk);
        end
    endtask
    task automatic ts_run(input logic [7:0] d, input logic m);
        int ts_k;
        int cap_k;
        ts_k = 0;
        cap_k = 0;
        wb(12'h48c, 1'b1, {24'h0, d});
        wb(12'h7fc, 1'b1, {31'h0, m});
        @(posedge sys_clk);
        trig <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
        for (int k = 0; k < 24; k++) begin
            @(posedge sys_clk);
            if (timestamp_out === 1'b1 && ts_k == 0) ts_k = k;
            if (capture_out === 1'b1) cap_k = k;
        end
        chk(32'(ts_k), m ? 32'(d) + 32'h2 : 32'h0);
        chk(32'(cap_k), m ? 32'h0 : 32'h2);
    endtask
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o, exp_q.pop_front());
        if (cyc_cnt == 20000) begin
            miscompares++;
            stop_test;
        end
    end
    initial begin
        void'($urandom(32'hf1dd5da7));
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], 32'h0);
        wb(12'h4a0, 1'b1, 32'hff);
        wb(12'h4a8, 1'b1, 32'hff);
        wb_sel_i <= 4'he;
        wb(12'h7fc, 1'b1, 32'h1);
        wb_sel_i <= 4'hf;
        rd(12'h4a0, 32'h0);
        rd(12'h4a8, 32'h0);
        rd(12'h7fc, 32'h0);
        $display("test registers done");
        fire(16);
        wb(12'h488, 1'b1, 32'h0a);
        rd(12'h488, 32'h0a);
        fire(16);
        wb(12'h488, 1'b1, 32'h0);
        fire(1);
        rd(12'h4a0, {24'h0, hv, sv});
        rd(12'h4a4, {28'h0, pv});
        rd(12'h4a8, 32'h1d);
        fire(227);
        rd(12'h4a8, 32'h0);
        $display("test capture done");
        for (int i = 0; i < 4; i++) begin
            v = {2'h0, 1'($urandom), 3'h0, 2'(i)};
            wb(12'h800, 1'b1, {24'h0, v});
            @(posedge sys_clk);
            chk({29'h0, q_ignore_out, op_mode_out}, {29'h0, v[5], v[1:0]});
            rd(12'h800, {24'h0, v});
        end
        $display("test modes done");
        ts_run(8'h00, 1'b1);
        ts_run(8'($urandom_range(1, 15)), 1'b1);
        ts_run(8'($urandom_range(1, 15)), 1'b0);
        $display("test timestamp done");
        stop_test;
    end
endmodule
bind srcm_monitor srcm_chk #(.DIV_LEN(DIV_LEN)) srcm_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .sysref_in(sysref_in), .capture_out(capture_out), .timestamp_out(timestamp_out),
    .op_mode_out(op_mode_out));
